// *** hdl/spi_legacy_pkg.sv ***
/*
 Constants for the legacy four-wire serial slave: register offsets,
 bit positions, link states and status codes.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package spi_legacy_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] OFF_TXDATA  = 8'h00;
    localparam logic [7:0] OFF_RXDATA  = 8'h04;
    localparam logic [7:0] OFF_BUFSTAT = 8'h08;
    localparam logic [7:0] OFF_INTSTAT = 8'h0c;
    localparam logic [7:0] OFF_INTMASK = 8'h10;

    // ========================================================
    // Status byte bit positions
    localparam int SB_RX_FULL   = 0;
    localparam int SB_TX_EMPTY  = 1;
    localparam int SB_RX_IRQ_EN = 4;
    localparam int SB_TX_IRQ_EN = 5;

    // ========================================================
    // Event bits, shared by status and mask registers
    localparam int EV_W     = 3;
    localparam int EV_RX    = 0;
    localparam int EV_TX    = 1;
    localparam int EV_ABORT = 2;

    // ========================================================
    // Link sequencing
    localparam logic [2:0] SETUP_LAST = 3'h1;
    localparam logic [2:0] DATA_LAST  = 3'h7;
    localparam logic       STAT_OK    = 1'h0;
    localparam logic       STAT_FAIL  = 1'h1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SETUP = 2'h1,
        ST_DATA  = 2'h3,
        ST_STAT  = 2'h2
    } link_state_e;

    // ========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** hdl/legacy_spi_slave.sv ***
/*
 Legacy four-wire serial slave with one-byte transmit and receive
 buffers, an AXI4-Lite register slave and a level interrupt.
 Assumes the serial clock is far slower than mclk_i (20 MHz), so the
 synchronised link inputs can be edge-detected on the system clock.
*/
// Implementation choices: the register offsets and the AXI4-Lite slave port.

module legacy_spi_slave (
    input  wire logic                     mclk_i,   // System clock
    input  wire logic                     rstn_i,   // Async reset
    input  wire logic [spi_legacy_pkg::ADDR_W-1:0] awaddr_i, // Wr addr
    input  wire logic                     awvalid_i, // Wr addr valid
    output logic                          awready_o, // Wr addr ready
    input  wire logic [31:0]              wdata_i,  // Wr data
    input  wire logic [3:0]               wstrb_i,  // Byte enables
    input  wire logic                     wvalid_i, // Wr data valid
    output logic                          wready_o, // Wr data ready
    output logic [1:0]                    bresp_o,  // Wr response
    output logic                          bvalid_o, // Wr resp valid
    input  wire logic                     bready_i, // Wr resp ready
    input  wire logic [spi_legacy_pkg::ADDR_W-1:0] araddr_i, // Rd addr
    input  wire logic                     arvalid_i, // Rd addr valid
    output logic                          arready_o, // Rd addr ready
    output logic [31:0]                   rdata_o,  // Rd data
    output logic [1:0]                    rresp_o,  // Rd response
    output logic                          rvalid_o, // Rd data valid
    input  wire logic                     rready_i, // Rd data ready
    input  wire logic                     sclk_i,   // Serial clock
    input  wire logic                     ss_i,     // Select, high
    input  wire logic                     mosi_i,   // Serial in
    output logic                          miso_o,   // Serial out
    output logic                          irq_o     // Interrupt
);

    // ========================================================
    // Link input synchronisers
    logic [2:0] sclk_q;
    logic [1:0] ss_q;
    logic [1:0] mosi_q;
    logic       rise;
    logic       ss_s;
    logic       mosi_s;

    // Two stages each; third sclk stage for edge detect
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sclk_q <= 3'h0;
            ss_q   <= 2'h0;
            mosi_q <= 2'h0;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            ss_q   <= {ss_q[0], ss_i};
            mosi_q <= {mosi_q[0], mosi_i};
        end
    end

    assign rise   = sclk_q[1] & ~sclk_q[2];
    assign ss_s   = ss_q[1];
    assign mosi_s = mosi_q[1];

    // ========================================================
    // Buffer and interrupt state
    spi_legacy_pkg::link_state_e state_ff, nxt_state;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic       miso_ff, nxt_miso;
    logic       rw_ff, nxt_rw;
    logic       addr_ff, nxt_addr;
    logic       fresh_ff, nxt_fresh;
    logic       do_pop, do_push, do_abort;
    logic [7:0] tx_data_ff, rx_data_ff;
    logic       tx_full_ff, rx_full_ff;
    logic [spi_legacy_pkg::EV_W-1:0] int_sts_ff, int_mask_ff;
    logic [spi_legacy_pkg::EV_W-1:0] events;
    logic       irq_ff;
    logic [7:0] stat_byte;
    logic       op_read, op_stat, op_wr, stat_bit;
    logic [7:0] shift_in;

    // Shifter contents with the current serial bit appended
    assign shift_in = {sh_ff[6:0], mosi_s};

    // Operation decode from setup bits
    assign op_read = rw_ff & ~addr_ff;
    assign op_stat = rw_ff & addr_ff;
    assign op_wr   = ~rw_ff & ~addr_ff;
    assign stat_bit = op_read ? ~fresh_ff
                    : op_wr   ? rx_full_ff
                    : spi_legacy_pkg::STAT_OK;

    // Status byte as shifted out
    always_comb
    begin
        stat_byte = 8'h00;
        stat_byte[spi_legacy_pkg::SB_RX_FULL]   = rx_full_ff;
        stat_byte[spi_legacy_pkg::SB_TX_EMPTY]  = ~tx_full_ff;
        stat_byte[spi_legacy_pkg::SB_RX_IRQ_EN] =
            int_mask_ff[spi_legacy_pkg::EV_RX];
        stat_byte[spi_legacy_pkg::SB_TX_IRQ_EN] =
            int_mask_ff[spi_legacy_pkg::EV_TX];
    end

    // ========================================================
    // Link sequencer, one step per serial rising edge
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_miso  = miso_ff;
        nxt_rw    = rw_ff;
        nxt_addr  = addr_ff;
        nxt_fresh = fresh_ff;
        do_pop    = 1'b0;
        do_push   = 1'b0;
        do_abort  = 1'b0;
        if (!ss_s && (state_ff == spi_legacy_pkg::ST_SETUP ||
                      state_ff == spi_legacy_pkg::ST_DATA))
        begin
            nxt_state = spi_legacy_pkg::ST_IDLE;
            nxt_miso  = 1'b0;
            do_abort  = 1'b1;
        end
        else if (!ss_s && state_ff == spi_legacy_pkg::ST_STAT)
        begin
            nxt_state = spi_legacy_pkg::ST_IDLE;
            nxt_miso  = 1'b0;
        end
        else if (rise)
        begin
            case (state_ff)
                spi_legacy_pkg::ST_IDLE:
                begin
                    if (ss_s && mosi_s)
                    begin
                        nxt_state = spi_legacy_pkg::ST_SETUP;
                        nxt_cnt   = 3'h0;
                    end
                end
                spi_legacy_pkg::ST_SETUP:
                begin
                    if (cnt_ff != spi_legacy_pkg::SETUP_LAST)
                    begin
                        nxt_rw  = mosi_s;
                        nxt_cnt = spi_legacy_pkg::SETUP_LAST;
                    end
                    else
                    begin
                        nxt_addr  = mosi_s;
                        nxt_fresh = tx_full_ff;
                        nxt_sh    = !rw_ff ? 8'h00
                                  : mosi_s ? stat_byte
                                  : tx_data_ff;
                        nxt_miso  = rw_ff & nxt_sh[7];
                        nxt_cnt   = 3'h0;
                        nxt_state = spi_legacy_pkg::ST_DATA;
                    end
                end
                spi_legacy_pkg::ST_DATA:
                begin
                    nxt_sh   = shift_in;
                    nxt_cnt  = 3'(cnt_ff + 3'h1);
                    nxt_miso = rw_ff & sh_ff[6];
                    if (cnt_ff == spi_legacy_pkg::DATA_LAST)
                    begin
                        nxt_state = spi_legacy_pkg::ST_STAT;
                        nxt_miso  = stat_bit;
                        do_pop    = op_read & fresh_ff;
                        do_push   = op_wr & ~rx_full_ff;
                    end
                end
                spi_legacy_pkg::ST_STAT:
                begin
                    nxt_state = spi_legacy_pkg::ST_IDLE;
                    nxt_miso  = 1'b0;
                end
                default:
                begin
                    nxt_state = spi_legacy_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= spi_legacy_pkg::ST_IDLE;
            cnt_ff   <= 3'h0;
            sh_ff    <= 8'h00;
            miso_ff  <= 1'b0;
            rw_ff    <= 1'b0;
            addr_ff  <= 1'b0;
            fresh_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            miso_ff  <= nxt_miso;
            rw_ff    <= nxt_rw;
            addr_ff  <= nxt_addr;
            fresh_ff <= nxt_fresh;
        end
    end

    // ========================================================
    // AXI4-Lite slave
    logic        awready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, rd_mux;
    logic        wr_fire, rd_fire, wr_hit, rd_hit;
    logic        cpu_tx_wr, cpu_rx_pop, istat_wr, imask_wr;

    function automatic logic at(
        input logic [spi_legacy_pkg::ADDR_W-1:0] a,
        input logic [7:0]                        off
    );
        return a == off;
    endfunction

    // Handshake and decode
    assign wr_fire    = awready_ff & awvalid_i & wvalid_i;
    assign rd_fire    = arready_ff & arvalid_i;
    assign cpu_tx_wr  = wr_fire & wstrb_i[0] & ~tx_full_ff &
                        at(awaddr_i, spi_legacy_pkg::OFF_TXDATA);
    assign istat_wr   = wr_fire & wstrb_i[0] &
                        at(awaddr_i, spi_legacy_pkg::OFF_INTSTAT);
    assign imask_wr   = wr_fire & wstrb_i[0] &
                        at(awaddr_i, spi_legacy_pkg::OFF_INTMASK);
    assign cpu_rx_pop = rd_fire &
                        at(araddr_i, spi_legacy_pkg::OFF_RXDATA);
    assign wr_hit = at(awaddr_i, spi_legacy_pkg::OFF_TXDATA)
                  | at(awaddr_i, spi_legacy_pkg::OFF_RXDATA)
                  | at(awaddr_i, spi_legacy_pkg::OFF_BUFSTAT)
                  | at(awaddr_i, spi_legacy_pkg::OFF_INTSTAT)
                  | at(awaddr_i, spi_legacy_pkg::OFF_INTMASK);
    assign rd_hit = at(araddr_i, spi_legacy_pkg::OFF_TXDATA)
                  | at(araddr_i, spi_legacy_pkg::OFF_RXDATA)
                  | at(araddr_i, spi_legacy_pkg::OFF_BUFSTAT)
                  | at(araddr_i, spi_legacy_pkg::OFF_INTSTAT)
                  | at(araddr_i, spi_legacy_pkg::OFF_INTMASK);

    // Read data selection
    assign rd_mux =
        at(araddr_i, spi_legacy_pkg::OFF_TXDATA)  ? {24'h0, tx_data_ff}
      : at(araddr_i, spi_legacy_pkg::OFF_RXDATA)  ? {24'h0, rx_data_ff}
      : at(araddr_i, spi_legacy_pkg::OFF_BUFSTAT) ? {24'h0, stat_byte}
      : at(araddr_i, spi_legacy_pkg::OFF_INTSTAT) ? {29'h0, int_sts_ff}
      : at(araddr_i, spi_legacy_pkg::OFF_INTMASK) ? {29'h0, int_mask_ff}
      : 32'h0;

    // Write channel: take address and data together
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= spi_legacy_pkg::RESP_OKAY;
        end
        else
        begin
            awready_ff <= awvalid_i & wvalid_i & ~awready_ff & ~bvalid_ff;
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? spi_legacy_pkg::RESP_OKAY
                                    : spi_legacy_pkg::RESP_SLVERR;
            end
            else if (bready_i)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= spi_legacy_pkg::RESP_OKAY;
        end
        else
        begin
            arready_ff <= arvalid_i & ~arready_ff & ~rvalid_ff;
            if (rd_fire)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_mux;
                rresp_ff  <= rd_hit ? spi_legacy_pkg::RESP_OKAY
                                    : spi_legacy_pkg::RESP_SLVERR;
            end
            else if (rready_i)
            begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ========================================================
    // Buffers and interrupts; hardware set wins over clear
    assign events = {do_abort, do_pop, do_push};

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_data_ff  <= 8'h00;
            tx_full_ff  <= 1'b0;
            rx_data_ff  <= 8'h00;
            rx_full_ff  <= 1'b0;
            int_sts_ff  <= '0;
            int_mask_ff <= '0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            if (cpu_tx_wr)
                tx_data_ff <= wdata_i[7:0];
            tx_full_ff <= cpu_tx_wr | (tx_full_ff & ~do_pop);
            if (do_push)
                rx_data_ff <= shift_in;
            rx_full_ff <= do_push | (rx_full_ff & ~cpu_rx_pop);
            int_sts_ff <= (int_sts_ff & ~({spi_legacy_pkg::EV_W{istat_wr}}
                          & wdata_i[spi_legacy_pkg::EV_W-1:0])) | events;
            if (imask_wr)
                int_mask_ff <= wdata_i[spi_legacy_pkg::EV_W-1:0];
            irq_ff <= |((int_sts_ff | events) & int_mask_ff);
        end
    end

    assign awready_o = awready_ff;
    assign wready_o  = awready_ff;
    assign bvalid_o  = bvalid_ff;
    assign bresp_o   = bresp_ff;
    assign arready_o = arready_ff;
    assign rvalid_o  = rvalid_ff;
    assign rdata_o   = rdata_ff;
    assign rresp_o   = rresp_ff;
    assign miso_o    = miso_ff;
    assign irq_o     = irq_ff;

    // ========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    logic last_edge;
    assign last_edge = rise & ss_s & (cnt_ff == spi_legacy_pkg::DATA_LAST)
                     & (state_ff == spi_legacy_pkg::ST_DATA);

    a_frame_start: assert property (
        state_ff == spi_legacy_pkg::ST_IDLE && rise && ss_s && mosi_s
        |=> state_ff == spi_legacy_pkg::ST_SETUP)
        else $error("start not taken");
    a_read_fresh: assert property (
        last_edge && op_read && fresh_ff
        |=> !miso_o && !tx_full_ff && int_sts_ff[spi_legacy_pkg::EV_TX])
        else $error("fresh read wrong");
    a_read_stale: assert property (
        last_edge && op_read && !fresh_ff |=> miso_o)
        else $error("stale read not flagged");
    a_write_accept: assert property (
        last_edge && op_wr && !rx_full_ff
        |=> !miso_o && rx_full_ff
            && rx_data_ff == $past(shift_in))
        else $error("write not stored");
    a_write_reject: assert property (
        last_edge && op_wr && rx_full_ff
        |=> miso_o && $stable(rx_data_ff))
        else $error("write not rejected");
    a_stat_trail: assert property (
        last_edge && op_stat |=> !miso_o)
        else $error("status trail not zero");
    a_stat_byte: assert property (
        state_ff == spi_legacy_pkg::ST_SETUP && rise && ss_s
        && cnt_ff == spi_legacy_pkg::SETUP_LAST && rw_ff && mosi_s
        |=> sh_ff == $past(stat_byte) && miso_o == $past(stat_byte[7]))
        else $error("status byte wrong");
    a_msb_order: assert property (
        state_ff == spi_legacy_pkg::ST_DATA && rise && ss_s && rw_ff
        && cnt_ff != spi_legacy_pkg::DATA_LAST
        |=> miso_o == $past(sh_ff[6]))
        else $error("bit order wrong");
    a_status_hold: assert property (
        state_ff == spi_legacy_pkg::ST_STAT && !rise && ss_s
        |=> $stable(miso_o))
        else $error("status bit moved");
    a_abort_clean: assert property (
        do_abort |=> state_ff == spi_legacy_pkg::ST_IDLE
        && int_sts_ff[spi_legacy_pkg::EV_ABORT] && $stable(rx_data_ff)
        && (tx_full_ff || !$past(tx_full_ff)))
        else $error("abort not clean");

    c_read_fresh: cover property (last_edge && op_read && fresh_ff);
    c_write_full: cover property (last_edge && op_wr && rx_full_ff);
    c_status_read: cover property (last_edge && op_stat);
    c_abort: cover property (do_abort);

endmodule

// *** verification/spi_master_model.sv ***
/*
 Behavioural master for the legacy serial link, one frame per call.
 Assumes the slave settles its serial output well within half of the
 400 ns link period.
*/
module spi_master_model (
    output logic      sclk_o, // Link clock, low outside frames but for one trailing pulse
    output logic      ss_o,   // Select, active high
    output logic      mosi_o, // Serial data to the slave
    input  wire logic miso_i  // Serial data from the slave
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================================
    // Idle levels
    initial
    begin
        sclk_o = 1'b0;
        ss_o   = 1'b0;
        mosi_o = 1'b0;
    end

    // ========================================================
    // Frame: start, two setup bits, byte, status bit
    task automatic frame(
        input  logic       rw,    // One for reads
        input  logic       tgt,   // One for the status byte
        input  logic [7:0] wbyte, // Byte sent on writes
        input  int         cut,   // Edge at which select drops early
        output logic [7:0] rbyte, // Byte shifted back
        output logic       stat   // Trailing status bit
    );
        logic [11:0] pat;
        pat   = {1'b1, rw, tgt, wbyte, 1'b0};
        rbyte = 8'h00;
        stat  = 1'b1;
        // Step off the system clock edge to avoid sampling races
        #10;
        for (int e = 0; e < 12 && e != cut; e++)
        begin
            // Lines change a half period before each rising edge
            ss_o   = 1'b1;
            mosi_o = (rw && e > 2) ? ~e[0] : pat[11-e];
            #200 sclk_o = 1'b1;
            if (e > 2 && e < 11)
                rbyte[10-e] = miso_i;
            if (e == 11)
                stat = miso_i;
            #200 sclk_o = 1'b0;
        end
        // Select released for a full cycle; also drops a cut frame
        ss_o   = 1'b0;
        mosi_o = 1'b0;
        #200 sclk_o = 1'b1;
        #200 sclk_o = 1'b0;
        // Return on a system clock edge again
        #390;
    endtask
endmodule

// *** verification/legacy_spi_slave_bench.sv ***
/*
 Self-checking bench for the legacy serial slave: bus tasks, link
 frames through the master model, expected values from the layout.
 Assumes the package and the master model are compiled first.
*/
module legacy_spi_slave_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================================
    // Signals
    logic        clk, rstn, sclk, ss, mosi, miso, irq, st;
    logic [7:0]  awaddr, araddr, rb;
    logic [31:0] wdata, rdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          fail_count;
    int          checked;

    legacy_spi_slave legacy_spi_slave_i (
        .mclk_i(clk), .rstn_i(rstn),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
        .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
        .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
        .rvalid_o(rvalid), .rready_i(rready), .sclk_i(sclk),
        .ss_i(ss), .mosi_i(mosi), .miso_o(miso), .irq_o(irq)
    );

    spi_master_model spi_master_model_i (
        .sclk_o(sclk), .ss_o(ss), .mosi_o(mosi), .miso_i(miso)
    );

    // ========================================================
    // Checks and closing
    task automatic end_of_test();
        $display("checked %0d, fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: bit %b, expected %b", $time, got,
                     exp);
        end
    endtask

    task automatic hang();
        fail_count++;
        $display("wrong value at %0t: wait ran out", $time);
        end_of_test();
    endtask

    // ========================================================
    // Bus and link access
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = spi_legacy_pkg::RESP_OKAY);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        bready <= 1'b0;
        if (n == 40)
            hang();
        chk_word({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er = spi_legacy_pkg::RESP_OKAY);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        rready <= 1'b0;
        if (n == 40)
            hang();
        chk_word(rdata, exp);
        chk_word({30'h0, rresp}, {30'h0, er});
    endtask

    // Whole frame; the byte is compared on reads only
    task automatic link(input logic rw, input logic tgt, input logic [7:0] wb,
                        input logic [7:0] eb, input logic es);
        spi_master_model_i.frame(rw, tgt, wb, 12, rb, st);
        if (rw)
            chk_word({24'h0, rb}, {24'h0, eb});
        chk_bit(st, es);
    endtask

    // Interrupt level, one cycle of lag allowed
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        chk_bit(irq, e);
    endtask

    // ========================================================
    // Clock
    initial
    begin
        clk = 1'b0;
        forever
            #25 clk = ~clk;
    end

    // ========================================================
    // Test sequence
    initial
    begin
        rstn       = 1'b0;
        awaddr     = 8'h00;
        araddr     = 8'h00;
        wdata      = 32'h0;
        awvalid    = 1'b0;
        wvalid     = 1'b0;
        bready     = 1'b0;
        arvalid    = 1'b0;
        rready     = 1'b0;
        fail_count = 0;
        checked    = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(spi_legacy_pkg::OFF_BUFSTAT, 32'h2);
        rd(8'h14, 32'h0, spi_legacy_pkg::RESP_SLVERR);
        wr(8'h14, 32'hff, spi_legacy_pkg::RESP_SLVERR);
        link(1'b1, 1'b1, 8'h00, 8'h02, 1'b0);
        wr(spi_legacy_pkg::OFF_INTMASK, 32'h7);
        rd(spi_legacy_pkg::OFF_INTMASK, 32'h7);
        link(1'b1, 1'b1, 8'h00, 8'h32, 1'b0);
        wr(spi_legacy_pkg::OFF_TXDATA, 32'ha5);
        wr(spi_legacy_pkg::OFF_TXDATA, 32'h11);
        link(1'b1, 1'b1, 8'h00, 8'h30, 1'b0);
        link(1'b1, 1'b0, 8'h00, 8'ha5, 1'b0);
        irq_is(1'b1);
        rd(spi_legacy_pkg::OFF_INTSTAT, 32'h2);
        link(1'b1, 1'b0, 8'h00, 8'ha5, 1'b1);
        wr(spi_legacy_pkg::OFF_INTSTAT, 32'h2);
        irq_is(1'b0);
        link(1'b0, 1'b0, 8'h3c, 8'h00, 1'b0);
        link(1'b1, 1'b1, 8'h00, 8'h33, 1'b0);
        link(1'b0, 1'b0, 8'h99, 8'h00, 1'b1);
        rd(spi_legacy_pkg::OFF_RXDATA, 32'h3c);
        link(1'b0, 1'b0, 8'h99, 8'h00, 1'b0);
        rd(spi_legacy_pkg::OFF_RXDATA, 32'h99);
        wr(spi_legacy_pkg::OFF_TXDATA, 32'h5a);
        spi_master_model_i.frame(1'b1, 1'b0, 8'h00, 6, rb, st);
        spi_master_model_i.frame(1'b0, 1'b0, 8'h77, 8, rb, st);
        rd(spi_legacy_pkg::OFF_INTSTAT, 32'h5);
        rd(spi_legacy_pkg::OFF_BUFSTAT, 32'h30);
        link(1'b1, 1'b0, 8'h00, 8'h5a, 1'b0);
        wr(spi_legacy_pkg::OFF_INTMASK, 32'h0);
        irq_is(1'b0);
        wr(spi_legacy_pkg::OFF_INTSTAT, 32'h7);
        rd(spi_legacy_pkg::OFF_INTSTAT, 32'h0);
        link(1'b0, 1'b1, 8'hc3, 8'h00, 1'b0);
        rd(spi_legacy_pkg::OFF_INTSTAT, 32'h0);
        rd(spi_legacy_pkg::OFF_BUFSTAT, 32'h2);
        rd(spi_legacy_pkg::OFF_RXDATA, 32'h99);
        end_of_test();
    end
endmodule
